/* lcd_panel_model.sv */
`timescale 1ns/10ps
module lcd_panel_model (
    // Scan side of the block
    input wire logic [6:0] lineRow,
    input wire lcd_scan_pkg::lcd_drive_t lcdDrive,
    // Bench control
    input wire logic [1:0] fillCode,
    // Returned data
    output logic [319:0] pixelLine,
    output logic [6:0] litCommon
);
    // Rows past the panel hold nothing; the inverse makes a stray fetch visible
    always_comb
    begin
        pixelLine = {160{(lineRow < 7'h50) ? fillCode : ~fillCode}};
        litCommon = 7'h7F;
        for (int k = 0; k < 80; k++)
        begin
            if (lcdDrive.comSelect[k])
            begin
                litCommon = 7'(k);
            end
        end
    end
endmodule : lcd_panel_model

/* lcd_scan_defs.svh */
`ifndef LCD_SCAN_DEFS_SVH
`define LCD_SCAN_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL1 8'h00
`define OFS_CTRL2 8'h04
`define OFS_START_RASTER 8'h08
`define OFS_BLINK_FIRST 8'h0C
`define OFS_BLINK_LAST 8'h10
`define OFS_BLINK_MASK_A 8'h14
`define OFS_BLINK_MASK_B 8'h18
`define OFS_BLINK_MASK_C 8'h1C
`define OFS_PARTIAL_POS 8'h20
`define OFS_CONTRAST_ALT 8'h24
`define OFS_PALETTE 8'h28
`define OFS_STATUS 8'h2C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_STANDBY 0
`define BIT_DISPLAY_ON 1
`define BIT_SUPPLY_ON 2
`define BIT_SCAN_DIR 3
`define BIT_BLINK_EN 0
`define BIT_GREY4 1
`define BIT_DUTY_LO 2
`define BIT_DUTY_HI 3
`define ALT_SEL_LSB 5

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define DUTY_80 2'h0
`define DUTY_64 2'h1
`define DUTY_32 2'h2
`define DUTY_8 2'h3
`define PALETTE_RST 20'hFDD60
`define PARTIAL_GROUPS 4'hA
`define PARTIAL_LOW_GROUPS 4'h5
`define DISPLAY_ROWS 8'h50
`define BLINK_FRAMES_BITS 6

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 50000000
`define OSC_FAST_HZ 180000
`define OSC_SLOW_HZ 18000
`define OSC_FAST_DIV (`CLK_HZ / `OSC_FAST_HZ)
`define OSC_SLOW_DIV (`CLK_HZ / `OSC_SLOW_HZ)
`define STEPS_GREY32 5'h1F
`define STEPS_GREY4 5'h03
`define ALT_LINES_A 4'h7
`define ALT_LINES_B 4'hB
`define ALT_LINES_C 4'hD

`endif

/* lcd_scan_pkg.sv */
package lcd_scan_pkg;

    // ----------------------------------------
    // Bus and panel carriers
    // ----------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic [79:0] comSelect;
        logic [159:0] segOn;
        logic polarity;
        logic outputsOff;
    } lcd_drive_t;

    // ----------------------------------------
    // Whole state of the scan block
    // ----------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic standby;
        logic dispOn;
        logic supplyOn;
        logic scanDir;
        logic blinkEn;
        logic grey4;
        logic [1:0] duty;
        logic [6:0] startRaster;
        logic [6:0] blinkFirst;
        logic [6:0] blinkLast;
        logic [23:0] blinkMask;
        logic [3:0] partPos;
        logic [4:0] contrast;
        logic [1:0] altSel;
        logic [19:0] palette;
        logic [11:0] oscCnt;
        logic [4:0] step;
        logic [6:0] line;
        logic [5:0] frameCnt;
        logic blinkOff;
        logic [3:0] altCnt;
        logic [6:0] ramRow;
        lcd_drive_t drive;
    } scan_state_t;

endpackage : lcd_scan_pkg

/* lcd_scan_scroll_blink_ctrl.sv */
`timescale 1ns/10ps
`include "lcd_scan_defs.svh"
module lcd_scan_scroll_blink_ctrl #(
    parameter int FAST_DIV = `OSC_FAST_DIV,
    parameter int SLOW_DIV = `OSC_SLOW_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wishbone register port
    input wire lcd_scan_pkg::wb_req_t wbReq,
    output lcd_scan_pkg::wb_rsp_t wbRsp,
    // Display RAM line fetch
    output logic [6:0] lineRow,
    input wire logic [319:0] pixelLine,
    // Panel and analog control
    output lcd_scan_pkg::lcd_drive_t lcdDrive,
    output logic supplyControl,
    output logic oscSlowSel,
    output logic [4:0] contrastLevel
);

    lcd_scan_pkg::scan_state_t q;
    lcd_scan_pkg::scan_state_t n;
    logic partial;
    logic oscSlow;
    logic outOff;
    logic [4:0] stepLast;
    logic [6:0] rowsLast;
    logic [159:0] segNext;
    logic [79:0] comNext;
    logic [6:0] comIdx;
    logic [6:0] rowNext;
    logic [6:0] lineNext;
    logic [11:0] divLast;

    assign partial = (q.duty == `DUTY_8);
    assign oscSlow = q.grey4 | partial;
    assign outOff = q.standby | ~q.dispOn;
    assign stepLast = oscSlow ? (`STEPS_GREY4 - 5'h01) : (`STEPS_GREY32 - 5'h01);
    assign divLast = oscSlow ? 12'(SLOW_DIV - 1) : 12'(FAST_DIV - 1);

    // ----------------------------------------
    // Duty rows and next line
    // ----------------------------------------
    always_comb
    begin
        case (q.duty)
            `DUTY_80: rowsLast = 7'h4F;
            `DUTY_64: rowsLast = 7'h3F;
            `DUTY_32: rowsLast = 7'h1F;
            default: rowsLast = 7'h07;
        endcase
        lineNext = (q.line >= rowsLast) ? 7'h00 : q.line + 7'h01;
    end

    // ----------------------------------------
    // Common line for the next scan line
    // ----------------------------------------
    always_comb
    begin
        logic [6:0] top;
        logic [7:0] sum;
        top = 7'h00;
        sum = 8'h00;
        if (partial)
        begin
            if (q.partPos < `PARTIAL_LOW_GROUPS || q.partPos >= `PARTIAL_GROUPS)
            begin
                top = (q.partPos < `PARTIAL_LOW_GROUPS) ? {q.partPos[2:0], 3'h0} : 7'h00;
                comIdx = q.scanDir ? top + lineNext : top + 7'h07 - lineNext;
            end
            else
            begin
                top = 7'h4F - {q.partPos[2:0] - 3'h5, 3'h0};
                comIdx = q.scanDir ? top - lineNext : top - 7'h07 + lineNext;
            end
        end
        else
        begin
            comIdx = lineNext;
        end
        // RAM row follows the start raster, wrapping only at the full 80 rows
        sum = {1'b0, q.startRaster} + {1'b0, comIdx};
        if (sum >= 2 * `DISPLAY_ROWS)
        begin
            sum = sum - 8'(2 * `DISPLAY_ROWS);
        end
        else if (sum >= `DISPLAY_ROWS)
        begin
            sum = sum - `DISPLAY_ROWS;
        end
        rowNext = sum[6:0];
        comNext = '0;
        comNext[comIdx] = 1'b1;
    end

    // ----------------------------------------
    // Per pixel grey level and blink gating
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 160; gi++)
        begin : gPix
            logic [1:0] code;
            logic [4:0] level;
            logic rowIn;
            logic blank;
            assign code = pixelLine[2 * gi +: 2];
            // Fixed steps in 4-level and partial modes, palette otherwise
            assign level = oscSlow ? {3'h0, code} : q.palette[5 * code +: 5];
            assign rowIn = (q.ramRow >= q.blinkFirst) && (q.ramRow <= q.blinkLast);
            assign blank = q.blinkEn & q.blinkOff & rowIn & q.blinkMask[gi / 8];
            assign segNext[gi] = (q.step < level) & ~blank;
        end
    endgenerate

    // ----------------------------------------
    // Next state: bus, registers, scan timing
    // ----------------------------------------
    always_comb
    begin
        logic access;
        logic tick;
        logic lineEnd;
        logic frameEnd;
        logic [3:0] altLen;
        logic [31:0] wmask;
        logic [31:0] wv;
        logic [31:0] rv;
        access = 1'b0;
        tick = 1'b0;
        lineEnd = 1'b0;
        frameEnd = 1'b0;
        altLen = `ALT_LINES_A;
        wmask = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}}, {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};
        wv = 32'h0000_0000;
        rv = 32'h0000_0000;
        n = q;

        // Bus slave: answer one cycle after the request, drop ack after one
        access = wbReq.cyc & wbReq.stb & ~q.ack;
        n.ack = access;
        if (access)
        begin
            if (wbReq.adr == `OFS_CTRL1)
            begin
                rv = {28'h0, q.scanDir, q.supplyOn, q.dispOn, q.standby};
            end
            else if (wbReq.adr == `OFS_CTRL2)
            begin
                rv = {28'h0, q.duty, q.grey4, q.blinkEn};
            end
            else if (wbReq.adr == `OFS_START_RASTER)
            begin
                rv = {25'h0, q.startRaster};
            end
            else if (wbReq.adr == `OFS_BLINK_FIRST)
            begin
                rv = {25'h0, q.blinkFirst};
            end
            else if (wbReq.adr == `OFS_BLINK_LAST)
            begin
                rv = {25'h0, q.blinkLast};
            end
            else if (wbReq.adr == `OFS_BLINK_MASK_A)
            begin
                rv = {24'h0, q.blinkMask[7:0]};
            end
            else if (wbReq.adr == `OFS_BLINK_MASK_B)
            begin
                rv = {24'h0, q.blinkMask[15:8]};
            end
            else if (wbReq.adr == `OFS_BLINK_MASK_C)
            begin
                rv = {24'h0, q.blinkMask[23:16]};
            end
            else if (wbReq.adr == `OFS_PARTIAL_POS)
            begin
                rv = {28'h0, q.partPos};
            end
            else if (wbReq.adr == `OFS_CONTRAST_ALT)
            begin
                rv = {25'h0, q.altSel, q.contrast};
            end
            else if (wbReq.adr == `OFS_PALETTE)
            begin
                rv = {12'h0, q.palette};
            end
            else if (wbReq.adr == `OFS_STATUS)
            begin
                rv = {9'h0, q.drive.polarity, q.blinkOff, oscSlow, q.frameCnt, q.line, q.ramRow};
            end
            else
            begin
                rv = 32'h0000_0000;
            end
            n.rdat = wbReq.we ? 32'h0000_0000 : rv;
            wv = (rv & ~wmask) | (wbReq.dat & wmask);
            if (wbReq.we)
            begin
                if (wbReq.adr == `OFS_CTRL1)
                begin
                    n.standby = wv[`BIT_STANDBY];
                    n.dispOn = wv[`BIT_DISPLAY_ON];
                    n.supplyOn = wv[`BIT_SUPPLY_ON];
                    n.scanDir = wv[`BIT_SCAN_DIR];
                    if (wv[`BIT_STANDBY] & ~q.standby)
                    begin
                        n.dispOn = 1'b0;
                    end
                end
                else if (wbReq.adr == `OFS_CTRL2)
                begin
                    n.blinkEn = wv[`BIT_BLINK_EN];
                    n.grey4 = wv[`BIT_GREY4];
                    n.duty = {wv[`BIT_DUTY_HI], wv[`BIT_DUTY_LO]};
                end
                else if (q.standby)
                begin
                    n.partPos = q.partPos; // Only the two control registers take writes in standby
                end
                else if (wbReq.adr == `OFS_START_RASTER)
                begin
                    n.startRaster = wv[6:0];
                end
                else if (wbReq.adr == `OFS_BLINK_FIRST)
                begin
                    n.blinkFirst = wv[6:0];
                end
                else if (wbReq.adr == `OFS_BLINK_LAST)
                begin
                    n.blinkLast = wv[6:0];
                end
                else if (wbReq.adr == `OFS_BLINK_MASK_A)
                begin
                    n.blinkMask[7:0] = wv[7:0];
                end
                else if (wbReq.adr == `OFS_BLINK_MASK_B)
                begin
                    n.blinkMask[15:8] = wv[7:0];
                end
                else if (wbReq.adr == `OFS_BLINK_MASK_C)
                begin
                    n.blinkMask[23:16] = wv[7:0];
                end
                else if (wbReq.adr == `OFS_PARTIAL_POS)
                begin
                    n.partPos = wv[3:0];
                end
                else if (wbReq.adr == `OFS_CONTRAST_ALT)
                begin
                    n.contrast = wv[4:0];
                    n.altSel = wv[`ALT_SEL_LSB +: 2];
                end
                else if (wbReq.adr == `OFS_PALETTE)
                begin
                    n.palette = wv[19:0];
                end
            end
        end

        // Oscillator model: stopped in standby, running otherwise
        if (!q.standby)
        begin
            if (q.oscCnt >= divLast)
            begin
                n.oscCnt = 12'h000;
                tick = 1'b1;
            end
            else
            begin
                n.oscCnt = q.oscCnt + 12'h001;
            end
        end

        // N PWM steps per line, duty lines per frame
        if (tick)
        begin
            if (q.step >= stepLast)
            begin
                n.step = 5'h00;
                lineEnd = 1'b1;
            end
            else
            begin
                n.step = q.step + 5'h01;
            end
        end
        if (lineEnd)
        begin
            frameEnd = (q.line >= rowsLast);
            n.line = lineNext;
            n.ramRow = rowNext;
            n.drive.comSelect = comNext;
        end
        if (frameEnd)
        begin
            n.frameCnt = q.frameCnt + 6'h01;
            if (q.frameCnt == 6'h3F)
            begin
                n.blinkOff = ~q.blinkOff;
            end
        end
        if (!q.blinkEn)
        begin
            n.blinkOff = 1'b0; // Blink starts in the visible phase
        end

        // Alternation polarity
        case (q.altSel)
            2'h1: altLen = `ALT_LINES_A;
            2'h2: altLen = `ALT_LINES_B;
            default: altLen = `ALT_LINES_C;
        endcase
        if (q.altSel == 2'h0)
        begin
            n.altCnt = 4'h0;
            if (frameEnd)
            begin
                n.drive.polarity = ~q.drive.polarity;
            end
        end
        else if (lineEnd)
        begin
            if (q.altCnt >= altLen - 4'h1)
            begin
                n.altCnt = 4'h0;
                n.drive.polarity = ~q.drive.polarity;
            end
            else
            begin
                n.altCnt = q.altCnt + 4'h1;
            end
        end

        // Panel outputs: off state shows supply level on every line
        n.drive.outputsOff = outOff;
        n.drive.segOn = outOff ? 160'h0 : segNext;
        if (outOff)
        begin
            n.drive.comSelect = 80'h0;
        end

        if (!rst_n)
        begin
            n = '0; // Duty 1/80, blink off, frame alternation, display off
            n.palette = `PALETTE_RST;
            n.drive.outputsOff = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        q <= n;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign wbRsp.ack = q.ack;
    assign wbRsp.dat = q.rdat;
    assign lineRow = q.ramRow;
    assign lcdDrive = q.drive;
    assign supplyControl = q.supplyOn;
    assign oscSlowSel = oscSlow;
    // Only eight contrast levels in partial mode
    assign contrastLevel = partial ? {2'h0, q.contrast[2:0]} : q.contrast;

endmodule : lcd_scan_scroll_blink_ctrl

/* lcd_scan_scroll_blink_ctrl_chk.sv */
`timescale 1ns/10ps
`include "lcd_scan_defs.svh"
module lcd_scan_scroll_blink_ctrl_chk #(
    parameter int FAST_DIV = `OSC_FAST_DIV,
    parameter int SLOW_DIV = `OSC_SLOW_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register bus
    input wire lcd_scan_pkg::wb_req_t wbReq,
    input wire lcd_scan_pkg::wb_rsp_t wbRsp,
    // Panel side
    input wire logic [6:0] lineRow,
    input wire logic [319:0] pixelLine,
    input wire lcd_scan_pkg::lcd_drive_t lcdDrive,
    input wire logic supplyControl,
    input wire logic oscSlowSel,
    input wire logic [4:0] contrastLevel
);
    logic [3:0] ctrl2_q;
    logic [3:0] ctrl2_d;
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Shadow of the mode bits, taken at the same edge as the block takes the write
    always_comb
    begin
        ctrl2_d = ctrl2_q;
        if (wbReq.cyc && wbReq.stb && wbReq.we && !wbRsp.ack && wbReq.adr == `OFS_CTRL2 && wbReq.sel[0])
        begin
            ctrl2_d = wbReq.dat[3:0];
        end
    end

    always_ff @(posedge clk)
    begin
        ctrl2_q <= rst_n ? ctrl2_d : 4'h0;
    end

    a_ack_next: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
        else $error("request not answered in one cycle");
    a_ack_once: assert property (wbRsp.ack |=> !wbRsp.ack)
        else $error("ack longer than one cycle");
    a_write_zero: assert property (wbRsp.ack && $past(wbReq.we) |-> wbRsp.dat == 32'h0)
        else $error("write answer carries data");
    a_reset_state: assert property ($past(!rst_n) |-> lcdDrive.outputsOff && !oscSlowSel && !supplyControl)
        else $error("wrong state after reset");
    a_off_blank: assert property (lcdDrive.outputsOff && $past(lcdDrive.outputsOff)
        |-> (lcdDrive.comSelect | lcdDrive.segOn) == '0)
        else $error("lines driven while off");
    a_one_common: assert property (!lcdDrive.outputsOff |-> $onehot0(lcdDrive.comSelect))
        else $error("more than one common selected");
    a_osc_mode: assert property (oscSlowSel == (ctrl2_q[`BIT_GREY4] || ctrl2_q[3:2] == `DUTY_8))
        else $error("oscillator choice does not follow mode");
    a_part_contrast: assert property (ctrl2_q[3:2] == `DUTY_8 |-> contrastLevel[4:3] == 2'h0)
        else $error("partial contrast above eight levels");
    a_row_follows: assert property (!lcdDrive.outputsOff && $past(!lcdDrive.outputsOff)
        && $changed(lcdDrive.comSelect) |-> $changed(lineRow))
        else $error("common moved without a new row");
endmodule : lcd_scan_scroll_blink_ctrl_chk

bind lcd_scan_scroll_blink_ctrl lcd_scan_scroll_blink_ctrl_chk #(.FAST_DIV(FAST_DIV), .SLOW_DIV(SLOW_DIV)) chk (
    .clk(clk), .rst_n(rst_n), .wbReq(wbReq), .wbRsp(wbRsp), .lineRow(lineRow), .pixelLine(pixelLine),
    .lcdDrive(lcdDrive), .supplyControl(supplyControl), .oscSlowSel(oscSlowSel), .contrastLevel(contrastLevel));

/* lcd_scan_scroll_blink_ctrl_test.sv */
`timescale 1ns/10ps
`include "lcd_scan_defs.svh"
module lcd_scan_scroll_blink_ctrl_test;
    localparam int FD = 4;
    localparam int SD = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    lcd_scan_pkg::wb_req_t wbReq = '0;
    lcd_scan_pkg::wb_rsp_t wbRsp;
    lcd_scan_pkg::lcd_drive_t lcdDrive;
    logic [6:0] lineRow;
    logic [319:0] pixelLine;
    logic supplyControl;
    logic oscSlowSel;
    logic [4:0] contrastLevel;
    logic [1:0] fill = 2'h3;
    logic [6:0] com;
    logic [31:0] rd;
    int numErrors = 0;
    int numChecks = 0;
    int cycles = 0;
    int n;

    always #10 clk = ~clk;

    lcd_scan_scroll_blink_ctrl #(.FAST_DIV(FD), .SLOW_DIV(SD)) dut (.clk(clk), .rst_n(rst_n), .wbReq(wbReq),
        .wbRsp(wbRsp), .lineRow(lineRow), .pixelLine(pixelLine), .lcdDrive(lcdDrive),
        .supplyControl(supplyControl), .oscSlowSel(oscSlowSel), .contrastLevel(contrastLevel));
    lcd_panel_model panel (.lineRow(lineRow), .lcdDrive(lcdDrive), .fillCode(fill), .pixelLine(pixelLine),
        .litCommon(com));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic giveVerdict();
        if (numErrors == 0 && numChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : giveVerdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            numErrors++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        wbReq <= '{1'b1, 1'b1, we, a, 4'hF, d};
        do
        begin
            @(posedge clk);
            k++;
        end
        while (wbRsp.ack !== 1'b1 && k < 20);
        check(k < 20, 1);
        rd = wbRsp.dat;
        wbReq.cyc <= 1'b0;
        wbReq.stb <= 1'b0;
    endtask : xfer

    // Waits for the next line start; n holds the cycles it took
    task automatic waitLine();
        logic [6:0] p;
        p = com;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (com === p && n < 4000);
    endtask : waitLine

    task automatic countOn(int len, int exp);
        int c;
        c = 0;
        waitLine();
        repeat (len)
        begin
            @(posedge clk);
            c += lcdDrive.segOn[0];
        end
        check(c, exp);
    endtask : countOn

    task automatic scan(int lines, int rows);
        repeat (lines)
        begin
            waitLine();
            check(n, 3 * SD);
            check(lineRow, (com + 1) % 80);
            check(com < rows, 1);
        end
    endtask : scan

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic testReset();
        check(lcdDrive.outputsOff, 1);
        check({oscSlowSel, lcdDrive.polarity, contrastLevel}, 0);
        xfer(0, `OFS_CTRL2, 0);
        check(rd, 0);
        xfer(0, `OFS_PALETTE, 0);
        check(rd, `PALETTE_RST);
        xfer(0, 8'h30, 0);
        check(rd, 0);
    endtask : testReset

    task automatic testPartial();
        int lo;
        int s;
        int pv;
        int cv;
        for (int d = 0; d < 2; d++)
        begin
            for (int p = 0; p < 10; p++)
            begin
                xfer(1, `OFS_CTRL1, 32'h2);
                xfer(1, `OFS_CTRL2, 32'hC);
                xfer(1, `OFS_CTRL1, 32'h2 | (d << 3));
                xfer(1, `OFS_PARTIAL_POS, p);
                xfer(1, `OFS_START_RASTER, 0);
                xfer(1, `OFS_CONTRAST_ALT, 32'h1F);
                lo = (p < 5) ? 8 * p : 72 - 8 * (p - 5);
                s = ((p < 5) == (d == 1)) ? 1 : -1;
                repeat (9) waitLine();
                repeat (9)
                begin
                    pv = com;
                    waitLine();
                    cv = com;
                    check(n, 3 * SD);
                    check(cv >= lo && cv < lo + 8, 1);
                    check(cv - pv == s || cv - pv == -7 * s, 1);
                    check(lineRow, com);
                    check(lcdDrive.segOn[0], 1);
                end
                check({oscSlowSel, contrastLevel}, 6'h27);
            end
        end
    endtask : testPartial

    task automatic testBlink();
        int run;
        logic b;
        run = 0;
        b = 1'b0;
        xfer(1, `OFS_CTRL1, 32'hA);
        xfer(1, `OFS_PARTIAL_POS, 0);
        xfer(1, `OFS_START_RASTER, 1);
        xfer(1, `OFS_BLINK_FIRST, 2);
        xfer(1, `OFS_BLINK_LAST, 3);
        xfer(1, `OFS_BLINK_MASK_A, 1);
        xfer(1, `OFS_BLINK_MASK_B, 0);
        xfer(1, `OFS_BLINK_MASK_C, 0);
        xfer(1, `OFS_CTRL2, 32'hD);
        repeat (1600)
        begin
            waitLine();
            repeat (2) @(posedge clk);
            if (lineRow == 7'h2)
            begin
                b = !lcdDrive.segOn[0];
                check(lcdDrive.segOn[8], 1);
                if (b)
                    run++;
                else if (run > 0)
                    break;
            end
            if (lineRow == 7'h3)
                check(!lcdDrive.segOn[0], b);
            if (lineRow == 7'h4)
                check(lcdDrive.segOn[0], 1);
        end
        check(run, 64);
    endtask : testBlink

    task automatic testStandby();
        logic [31:0] s;
        xfer(0, `OFS_STATUS, 0);
        s = rd;
        repeat (60) @(posedge clk);
        xfer(0, `OFS_STATUS, 0);
        check(rd[13:7] != s[13:7], 1);
        xfer(1, `OFS_CTRL1, 32'hB);
        xfer(0, `OFS_CTRL1, 0);
        check(rd[1:0], 1);
        check(lcdDrive.outputsOff, 1);
        check((lcdDrive.comSelect | lcdDrive.segOn) == '0, 1);
        s = rd;
        xfer(0, `OFS_STATUS, 0);
        s = rd;
        repeat (60) @(posedge clk);
        xfer(0, `OFS_STATUS, 0);
        check(rd[19:0], s[19:0]);
        xfer(1, `OFS_START_RASTER, 5);
        xfer(0, `OFS_START_RASTER, 0);
        check(rd, 1);
        xfer(1, `OFS_CTRL2, 32'hC);
        xfer(0, `OFS_CTRL2, 0);
        check(rd, 32'hC);
        xfer(1, `OFS_CTRL1, 32'h6);
        repeat (100) @(posedge clk);
        check(lcdDrive.outputsOff, 0);
        check(supplyControl, 1);
    endtask : testStandby

    task automatic testScroll();
        xfer(1, `OFS_CTRL2, 32'h2);
        xfer(1, `OFS_START_RASTER, 1);
        repeat (2) waitLine();
        scan(82, 80);
        while (com !== 7'h0) waitLine();
        xfer(1, `OFS_CTRL2, 32'h6);
        repeat (2) waitLine();
        scan(66, 64);
        while (com !== 7'h0) waitLine();
        xfer(1, `OFS_CTRL2, 32'hA);
        repeat (2) waitLine();
        scan(34, 32);
    endtask : testScroll

    task automatic testGrey();
        fill <= 2'h1;
        countOn(24, 8);
        xfer(1, `OFS_CTRL2, 32'h4);
        waitLine();
        countOn(124, 44);
        check(n, 31 * FD);
        check(oscSlowSel, 0);
        xfer(1, `OFS_PALETTE, 32'hFDCA0);
        countOn(124, 20);
    endtask : testGrey

    // The alternation line count runs on across frame ends, so every measured interval is the full length
    task automatic testAlt();
        int e;
        int mx;
        int hit;
        xfer(1, `OFS_CTRL2, 32'h2);
        for (int c = 0; c < 4; c++)
        begin
            xfer(1, `OFS_CONTRAST_ALT, c << 5);
            e = 3 * SD * ((c == 0) ? 80 : (c == 1) ? 7 : (c == 2) ? 11 : 13);
            mx = 0;
            hit = 0;
            @(lcdDrive.polarity);
            repeat (3)
            begin
                n = 0;
                fork
                    @(lcdDrive.polarity);
                    forever @(posedge clk) n++;
                join_any
                disable fork;
                mx = (n > mx) ? n : mx;
                hit |= (n == e);
            end
            check(mx <= e, 1);
            check(hit, 1);
        end
    endtask : testAlt

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 95000)
        begin
            numErrors++;
            giveVerdict();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        testReset();
        testPartial();
        testBlink();
        testStandby();
        testScroll();
        testGrey();
        testAlt();
        // A reset in mid-run must bring back the reset values that testReset checks
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        testReset();
        giveVerdict();
    end
endmodule : lcd_scan_scroll_blink_ctrl_test
